// file: field_seq_pkg.sv
// field_seq_pkg.sv: constants and types of the field sequence register bank
// assumes one 100 MHz clock and classic wishbone access to the registers

package field_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and counts
  localparam int unsigned POS_W = 13;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned NUM_REGIONS = 9;
  localparam int unsigned NUM_WORDS = 9;
  localparam int unsigned DATA_W = 28;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned REGION_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_POS_0_1 = 6'h00;
  localparam logic [IDX_W-1:0] IDX_POS_2_3 = 6'h01;
  localparam logic [IDX_W-1:0] IDX_POS_4_5 = 6'h02;
  localparam logic [IDX_W-1:0] IDX_POS_6_7 = 6'h03;
  localparam logic [IDX_W-1:0] IDX_POS_8 = 6'h04;
  localparam logic [IDX_W-1:0] IDX_SEL_A = 6'h05;
  localparam logic [IDX_W-1:0] IDX_SEL_B = 6'h06;
  localparam logic [IDX_W-1:0] IDX_RESERVED = 6'h07;
  localparam logic [IDX_W-1:0] IDX_CLAMP = 6'h08;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h09;

  ////////////////////////////////////////////////////////////////////////////
  // field positions inside the words
  localparam int unsigned POS_LO_LSB = 0;
  localparam int unsigned POS_HI_LSB = 13;
  localparam int unsigned POS_PER_WORD = 2;
  localparam int unsigned SELS_PER_WORD = 5;
  localparam int unsigned CLAMP_POL_LSB = 0;
  localparam int unsigned CLAMP_SET_LSB = 9;
  localparam int unsigned STAT_REGION_LSB = 0;
  localparam int unsigned STAT_PEND_BIT = 4;
  localparam int unsigned STAT_VALID_BIT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [DATA_W-1:0] WORD_RESET = 28'h000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [DATA_W-1:0] word_t;
  typedef word_t bank_t [NUM_WORDS];

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [POS_W-1:0] second;
    logic [POS_W-1:0] first;
  } toggle_pair_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

// file: vsync_edge.sv
// vsync_edge.sv: synchronises the vertical sync level and marks its rise
// assumes vertical sync may change at any time relative to ref_clk_i
`timescale 1ns/1ps
`default_nettype none

module vsync_edge (
  input wire logic ref_clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic vsync_i, // raw vertical sync level
  output logic rise_o // one-cycle pulse on rising edge
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // two-stage synchroniser, then a delayed copy for the edge
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= vsync_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign rise_o = sync_ff & ~prev_ff;

endmodule // vsync_edge
`default_nettype wire

// file: clamp_pulse_gen.sv
// clamp_pulse_gen.sv: black clamp level along a line from two toggles
// assumes pixel count from the timing core on the same clock
`timescale 1ns/1ps
`default_nettype none

module clamp_pulse_gen (
  input wire logic ref_clk_i, // system clock
  input wire logic nrst_i, // async reset, active low
  input wire logic [field_seq_pkg::POS_W-1:0] pixel_i, // pixel in line
  input wire logic start_pol_i, // level at line start
  input wire field_seq_pkg::toggle_pair_t toggles_i, // toggle positions
  output logic pulse_o // registered clamp level
);

  logic pulse_ff;
  logic nxt_pulse;

  always_comb begin
    nxt_pulse = start_pol_i ^ (pixel_i >= toggles_i.first)
                ^ (pixel_i >= toggles_i.second);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse_o = pulse_ff;

  a_clamp_start_lvl: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (pixel_i < toggles_i.first && pixel_i < toggles_i.second)
    |=> pulse_o == $past(start_pol_i))
    else $error("clamp does not begin at its start polarity");

  a_clamp_toggle_mid: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (pixel_i >= toggles_i.first && pixel_i < toggles_i.second)
    |=> pulse_o != $past(start_pol_i))
    else $error("clamp did not flip between its toggles");

endmodule // clamp_pulse_gen
`default_nettype wire

// file: field_sequence_registers.sv
// field_sequence_registers.sv: field register bank with vsync update,
// region lookup, pattern selection and black clamp generation
// assumes line and pixel counts come from the timing core on ref_clk_i,
// vertical sync is asynchronous, and a classic wishbone master
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module field_sequence_registers (
  input wire logic ref_clk_i, // 100 MHz system clock
  input wire logic nrst_i, // async reset, active low
  input wire field_seq_pkg::wb_req_t wb_req_i, // wishbone request
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic vertical_sync_i, // field boundary level
  input wire logic [field_seq_pkg::POS_W-1:0] line_cnt_i, // line in field
  input wire logic [field_seq_pkg::POS_W-1:0] pixel_cnt_i, // pixel in line
  input wire field_seq_pkg::toggle_pair_t clamp_toggle_set_a_i, // set a
  input wire field_seq_pkg::toggle_pair_t clamp_toggle_set_b_i, // set b
  output logic [field_seq_pkg::REGION_W-1:0] region_o, // current region
  output logic [field_seq_pkg::SEL_W-1:0] region_pattern_select_o, // pattern
  output logic black_clamp_pulse_o, // clamp level
  output logic config_valid_o // bank has been programmed and applied
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  field_seq_pkg::bank_t shadow_ff;
  field_seq_pkg::bank_t active_ff;
  field_seq_pkg::bus_state_t bus_state_ff;
  field_seq_pkg::bus_state_t nxt_bus_state;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic pending_ff;
  logic valid_ff;
  logic [field_seq_pkg::REGION_W-1:0] region_ff;
  logic [field_seq_pkg::REGION_W-1:0] nxt_region;
  logic [field_seq_pkg::SEL_W-1:0] sel_ff;
  logic vs_rise;
  logic req;
  logic wr_fire;
  logic [field_seq_pkg::IDX_W-1:0] idx;
  logic [field_seq_pkg::DATA_W-1:0] lane_mask;
  logic cur_pol;
  logic cur_set;
  field_seq_pkg::toggle_pair_t cur_toggles;

  ////////////////////////////////////////////////////////////////////////////
  // field decoding helpers

  // change position n out of a bank
  function automatic logic [field_seq_pkg::POS_W-1:0] pos_of(
    input field_seq_pkg::bank_t bank,
    input int unsigned n
  );
    field_seq_pkg::word_t w;
    w = bank[n / field_seq_pkg::POS_PER_WORD];
    if ((n % field_seq_pkg::POS_PER_WORD) == 0) begin
      pos_of = w[field_seq_pkg::POS_LO_LSB +: field_seq_pkg::POS_W];
    end else begin
      pos_of = w[field_seq_pkg::POS_HI_LSB +: field_seq_pkg::POS_W];
    end
  endfunction

  // pattern selector of region n
  function automatic logic [field_seq_pkg::SEL_W-1:0] sel_of(
    input field_seq_pkg::bank_t bank,
    input int unsigned n
  );
    field_seq_pkg::word_t w;
    int unsigned slot;
    w = bank[32'(field_seq_pkg::IDX_SEL_A)
             + n / field_seq_pkg::SELS_PER_WORD];
    slot = n % field_seq_pkg::SELS_PER_WORD;
    sel_of = w[slot * field_seq_pkg::SEL_W +: field_seq_pkg::SEL_W];
  endfunction

  // byte lanes to a bit mask over the stored width
  function automatic logic [field_seq_pkg::DATA_W-1:0] lanes(
    input logic [3:0] sel
  );
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    lanes = m[field_seq_pkg::DATA_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // vertical sync synchroniser

  vsync_edge u_vsync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .vsync_i(vertical_sync_i),
    .rise_o(vs_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle

  assign req = wb_req_i.cyc & wb_req_i.stb;
  assign idx = wb_req_i.adr[field_seq_pkg::ADR_W-1:2];
  assign wb_ack_o = (bus_state_ff == field_seq_pkg::BUS_ACK);
  // write lands at the same edge the master samples ack
  assign wr_fire = wb_ack_o & req & wb_req_i.we;
  assign lane_mask = lanes(wb_req_i.sel);

  // idle waits for a request, ack lasts exactly one cycle
  always_comb begin
    nxt_bus_state = bus_state_ff;
    unique case (bus_state_ff)
      field_seq_pkg::BUS_IDLE: begin
        if (req) begin
          nxt_bus_state = field_seq_pkg::BUS_ACK;
        end
      end
      field_seq_pkg::BUS_ACK: begin
        nxt_bus_state = field_seq_pkg::BUS_IDLE;
      end
      default: begin
        nxt_bus_state = field_seq_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_state_ff <= field_seq_pkg::BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // read mux; the reserved word and unmapped addresses read zero
  always_comb begin
    nxt_rdata = field_seq_pkg::READ_ZERO;
    if (idx == field_seq_pkg::IDX_STATUS) begin
      nxt_rdata[field_seq_pkg::STAT_REGION_LSB +: field_seq_pkg::REGION_W] =
        region_ff;
      nxt_rdata[field_seq_pkg::STAT_PEND_BIT] = pending_ff;
      nxt_rdata[field_seq_pkg::STAT_VALID_BIT] = valid_ff;
    end else if (idx < field_seq_pkg::IDX_STATUS) begin
      nxt_rdata[field_seq_pkg::DATA_W-1:0] = shadow_ff[idx[3:0]];
    end
  end

  // capture read data while idle so it stands through the ack cycle
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= field_seq_pkg::READ_ZERO;
    end else if (req && bus_state_ff == field_seq_pkg::BUS_IDLE) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_dat_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // shadow bank written by software

  for (genvar w = 0; w < field_seq_pkg::NUM_WORDS; w++) begin : g_shadow
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      // genvar cast to the index width so the address match is exact
      if (!nrst_i) begin
        shadow_ff[w] <= field_seq_pkg::WORD_RESET;
      end else if (wr_fire && idx == field_seq_pkg::IDX_W'(w)
                   && idx != field_seq_pkg::IDX_RESERVED) begin
        shadow_ff[w] <= (shadow_ff[w] & ~lane_mask)
                        | (wb_req_i.dat[field_seq_pkg::DATA_W-1:0]
                           & lane_mask);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active bank, refreshed only at a field boundary

  for (genvar w = 0; w < field_seq_pkg::NUM_WORDS; w++) begin : g_active
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        active_ff[w] <= field_seq_pkg::WORD_RESET;
      end else if (vs_rise) begin
        active_ff[w] <= shadow_ff[w];
      end
    end
  end

  // pending: a write not yet applied; a write in the vsync cycle wins
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pending_ff <= 1'b0;
    end else if (wr_fire && idx < field_seq_pkg::IDX_STATUS) begin
      pending_ff <= 1'b1;
    end else if (vs_rise) begin
      pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      valid_ff <= 1'b0;
    end else if (vs_rise && pending_ff) begin
      valid_ff <= 1'b1;
    end
  end

  assign config_valid_o = valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // region lookup along the field

  // regions in field order
  // a zero position past region 0 ends the list, since line 0 starts
  // the field anyway; unordered positions are not sorted
  always_comb begin
    logic stop;
    stop = 1'b0;
    nxt_region = '0;
    for (int unsigned n = 1; n < field_seq_pkg::NUM_REGIONS; n++) begin
      if (pos_of(active_ff, n) == '0) begin
        stop = 1'b1;
      end else if (!stop && line_cnt_i >= pos_of(active_ff, n)) begin
        nxt_region = field_seq_pkg::REGION_W'(n);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      region_ff <= '0;
      sel_ff <= '0;
    end else begin
      region_ff <= nxt_region;
      sel_ff <= sel_of(active_ff, 32'(nxt_region));
    end
  end

  assign region_o = region_ff;
  assign region_pattern_select_o = sel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // black clamp pulse for the current region

  assign cur_pol = active_ff[field_seq_pkg::IDX_CLAMP[3:0]]
                   [field_seq_pkg::CLAMP_POL_LSB + 32'(region_ff)];
  assign cur_set = active_ff[field_seq_pkg::IDX_CLAMP[3:0]]
                   [field_seq_pkg::CLAMP_SET_LSB + 32'(region_ff)];

  assign cur_toggles = cur_set ? clamp_toggle_set_b_i : clamp_toggle_set_a_i;

  clamp_pulse_gen u_clamp (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .pixel_i(pixel_cnt_i),
    .start_pol_i(cur_pol),
    .toggles_i(cur_toggles),
    .pulse_o(black_clamp_pulse_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_pos_hold_field: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !vs_rise |=> active_ff[0] == $past(active_ff[0])
                 && active_ff[4] == $past(active_ff[4]))
    else $error("change positions moved inside a field");

  a_pos_load_vsync: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    vs_rise |=> active_ff[4][12:0] == $past(shadow_ff[4][12:0])
                && active_ff[3][25:13] == $past(shadow_ff[3][25:13]))
    else $error("positions not loaded at vertical sync");

  a_sel_first_word: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (nxt_region == 4'h2 && !vs_rise)
    |=> region_pattern_select_o == active_ff[5][14:10])
    else $error("third region selector wrong");

  a_sel_ninth: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (nxt_region == 4'h8 && !vs_rise)
    |=> region_pattern_select_o == active_ff[6][19:15])
    else $error("ninth region selector wrong");

  // set a toggles seen at the clamp output
  a_clamp_use_a: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !active_ff[8][9 + 32'(region_ff)]
    |=> black_clamp_pulse_o == ($past(active_ff[8][32'(region_ff)])
        ^ ($past(pixel_cnt_i) >= $past(clamp_toggle_set_a_i.first))
        ^ ($past(pixel_cnt_i) >= $past(clamp_toggle_set_a_i.second))))
    else $error("clamp set a not used for a zero select");

  // set b toggles seen at the clamp output
  a_clamp_use_b: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    active_ff[8][9 + 32'(region_ff)]
    |=> black_clamp_pulse_o == ($past(active_ff[8][32'(region_ff)])
        ^ ($past(pixel_cnt_i) >= $past(clamp_toggle_set_b_i.first))
        ^ ($past(pixel_cnt_i) >= $past(clamp_toggle_set_b_i.second))))
    else $error("clamp set b not used for a one select");

  a_valid_cause: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(config_valid_o) |-> $past(vs_rise) && $past(pending_ff))
    else $error("valid rose without an applied write");

  a_region_order: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (nxt_region != 4'h0) |-> line_cnt_i >= pos_of(active_ff, 32'(nxt_region))
                             && pos_of(active_ff, 32'(nxt_region)) != '0)
    else $error("region entered before its change position");

  a_ack_single: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // a request seen while idle is answered at the very next edge
  a_ack_next: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (req && bus_state_ff == field_seq_pkg::BUS_IDLE) |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");

  // a write in the copy cycle misses the copy, so pending must survive
  a_pend_set_wins: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (wr_fire && idx < field_seq_pkg::IDX_STATUS) |=> pending_ff)
    else $error("pending lost for a write not yet applied");

  // a zero first change position keeps the field in region 0
  a_region_list_end: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (pos_of(active_ff, 1) == '0) |=> region_o == 4'h0)
    else $error("region left 0 with an empty position list");

endmodule // field_sequence_registers
`default_nettype wire

// file: tb_field_sequence_registers.sv
// tb_field_sequence_registers.sv: self-checking bench of the field bank
// assumes the designer's package and modules are compiled before this file
`timescale 1ns/1ps
`default_nettype none

module tb_field_sequence_registers;

  ////////////////////////////////////////////////////////////////////////////
  // signals and counters
  typedef struct packed {
    logic [5:0] idx;
    logic [31:0] dat;
    logic [31:0] exp;
  } row_t;

  logic ref_clk_i;
  logic nrst_i;
  field_seq_pkg::wb_req_t req;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic vsync;
  logic [12:0] line_cnt;
  logic [12:0] pixel_cnt;
  field_seq_pkg::toggle_pair_t set_a;
  field_seq_pkg::toggle_pair_t set_b;
  logic [3:0] region_o;
  logic [4:0] pattern_o;
  logic clamp_o;
  logic valid_o;
  logic [31:0] rd;
  row_t rows [11];
  logic [8:0] pol;
  logic [8:0] sel;
  field_seq_pkg::toggle_pair_t tg;
  logic [12:0] pix [5];
  logic exp_clamp;
  int bad_count;
  int checked;

  // one compare: counts every check, reports a mismatch at once
  `define CHK(got, exp) begin checked++; \
    if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end

  field_sequence_registers u_field_sequence_registers (
    .ref_clk_i(ref_clk_i), // clock
    .nrst_i(nrst_i), // reset
    .wb_req_i(req), // bus request
    .wb_dat_o(wb_dat_o), // read data
    .wb_ack_o(wb_ack_o), // acknowledge
    .vertical_sync_i(vsync), // field boundary
    .line_cnt_i(line_cnt), // line
    .pixel_cnt_i(pixel_cnt), // pixel
    .clamp_toggle_set_a_i(set_a), // first set
    .clamp_toggle_set_b_i(set_b), // second set
    .region_o(region_o), // region
    .region_pattern_select_o(pattern_o), // pattern
    .black_clamp_pulse_o(clamp_o), // clamp
    .config_valid_o(valid_o) // applied
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  // verdict and end of run, shared with the watchdog
  task automatic end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // classic single cycle; holds the request until ack is seen at an edge
  task automatic wb(input logic we, input logic [5:0] idx,
                    input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge ref_clk_i);
    req <= {1'b1, 1'b1, we, idx, 2'b00, 4'hF, wd};
    // no limit of its own: a missing ack is ended by the watchdog
    do begin
      @(posedge ref_clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    req <= '0;
  endtask

  // line and pixel set, then enough edges for region and clamp to settle
  task automatic probe(input logic [12:0] ln, input logic [12:0] px);
    @(posedge ref_clk_i);
    line_cnt <= ln;
    pixel_cnt <= px;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  // one field boundary; long enough high and low to be seen
  task automatic field_edge;
    @(posedge ref_clk_i);
    vsync <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    vsync <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    bad_count++;
    end_of_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    nrst_i = 1'b0;
    req = '0;
    vsync = 1'b0;
    line_cnt = 13'h0000;
    pixel_cnt = 13'h0000;
    set_a = {13'h00C8, 13'h0064};
    set_b = {13'h0096, 13'h0032};
    bad_count = 0;
    checked = 0;
    pix = '{13'h0000, 13'h004B, 13'h007D, 13'h00AF, 13'h00FA};
    // positions 10*n, selectors n+3, clamp pol 155 and set 0aa; zero spare
    rows[0] = '{6'h00, 32'h0001_4000, 32'h0001_4000};
    rows[1] = '{6'h01, 32'h0003_C014, 32'h0003_C014};
    rows[2] = '{6'h02, 32'h0006_4028, 32'h0006_4028};
    rows[3] = '{6'h03, 32'h0008_C03C, 32'h0008_C03C};
    rows[4] = '{6'h04, 32'h0000_0050, 32'h0000_0050};
    rows[5] = '{6'h05, 32'h0073_1483, 32'h0073_1483};
    rows[6] = '{6'h06, 32'h0005_A928, 32'h0005_A928};
    rows[7] = '{6'h07, 32'h0000_0000, 32'h0000_0000};
    rows[8] = '{6'h08, 32'h0001_5555, 32'h0001_5555};
    rows[9] = '{6'h0A, 32'h0FFF_FFFF, 32'h0000_0000};
    rows[10] = '{6'h09, 32'h0000_003F, 32'h0000_0010};
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK({region_o, pattern_o, clamp_o, valid_o}, 11'h000)
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    wb(1'b0, 6'h00, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    // writes keep spare bits zero, then read back
    foreach (rows[i]) begin
      wb(1'b1, rows[i].idx, rows[i].dat, rd);
      wb(1'b0, rows[i].idx, 32'h0000_0000, rd);
      `CHK(rd, rows[i].exp)
    end
    probe(13'h000F, 13'h0000);
    `CHK(region_o, 4'h0)
    `CHK(valid_o, 1'b0)
    field_edge;
    `CHK(valid_o, 1'b1)
    for (int r = 0; r < 9; r++) begin
      probe(13'(10 * r + 5), 13'h0000);
      `CHK(region_o, 4'(r))
      `CHK(pattern_o, 5'(r + 3))
    end
    // clamp per region across both sets
    pol = 9'h155;
    sel = 9'h0AA;
    for (int r = 0; r < 9; r++) begin
      for (int p = 0; p < 5; p++) begin
        probe(13'(10 * r + 5), pix[p]);
        tg = sel[r] ? set_b : set_a;
        exp_clamp = pol[r] ^ (pix[p] >= tg.first) ^ (pix[p] >= tg.second);
        `CHK(clamp_o, exp_clamp)
      end
    end
    // mid-field rewrite of position 1 must wait for the boundary
    wb(1'b1, 6'h00, 32'h0005_0000, rd);
    probe(13'h000F, 13'h0000);
    `CHK(region_o, 4'h1)
    wb(1'b0, 6'h09, 32'h0000_0000, rd);
    `CHK(rd[5:0], 6'h31)
    field_edge;
    probe(13'h000F, 13'h0000);
    `CHK(region_o, 4'h0)
    // last region still reached through position 8
    probe(13'h0055, 13'h0000);
    `CHK(pattern_o, 5'h0B)
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    #1;
    `CHK({region_o, pattern_o, clamp_o, valid_o}, 11'h000)
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    wb(1'b0, 6'h04, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    end_of_test;
  end

endmodule // tb_field_sequence_registers

`default_nettype wire
